// *** src/mbpwm_unit.sv ***
// Match based PWM unit: match registers, edge logic and output pins.
`timescale 1ns/100ps
`include "mbpwm_regs.svh"

module mbpwm_unit #(
    parameter int CNT_W = `MBPWM_CNT_W
) (
    // Clock, clock enable and reset.
    input  wire logic                                        clk,
    input  wire logic                                        ce,
    input  wire logic                                        rst_n,
    // Run control.
    input  wire logic                                        run,
    input  wire logic                                        cnt_clr,
    // Configuration, taken when cfg_load is high.
    input  wire logic                                        cfg_load,
    input  wire logic [CNT_W-1:0]                            prescale_max,
    input  wire logic [`MBPWM_NUM_MATCH-1:0][CNT_W-1:0]      match_val,
    input  wire logic [`MBPWM_NUM_MATCH-1:0]                 irq_en,
    input  wire logic [`MBPWM_NUM_MATCH-1:0]                 rst_en,
    input  wire logic [`MBPWM_NUM_MATCH-1:0]                 stop_en,
    input  wire logic [`MBPWM_NUM_OUT:1]                     dbl_edge,
    // Pins and events.
    output logic      [`MBPWM_NUM_OUT:1]                     pwm_out,
    output logic      [`MBPWM_NUM_MATCH-1:0]                 match_irq,
    output logic      [CNT_W-1:0]                            count_val,
    output logic                                             halted
);

    localparam int NM = `MBPWM_NUM_MATCH;
    localparam int NO = `MBPWM_NUM_OUT;
    localparam int C0 = `MBPWM_CYCLE_CH;

    // Widths the comparators and counters cannot serve are refused here.
    if (CNT_W < `MBPWM_CNT_W_MIN || CNT_W > `MBPWM_CNT_W) begin : g_bad_width
        $error("CNT_W out of range");
    end

    // Reset release through two flip-flops; only the second is read.
    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_sync_n = rst_s2_r;

    // Timer core and its link.
    mbpwm_tmr_if #(.CNT_W(CNT_W)) tif ();

    mbpwm_core #(
        .CNT_W      (CNT_W)
    ) u_core (
        .clk        (clk),
        .ce         (ce),
        .rst_sync_n (rst_sync_n),
        .tif        (tif)
    );

    // Match registers and match actions, kept as an array of words.
    logic [CNT_W-1:0]    match_reg_r [NM];
    logic [NM-1:0]       irq_en_r;
    logic [NM-1:0]       rst_en_r;
    logic [NM-1:0]       stop_en_r;
    logic [NO:1]         dbl_r;
    logic [CNT_W-1:0]    presc_r;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int k = 0; k < NM; k++) match_reg_r[k] <= '0;
            irq_en_r  <= '0;
            rst_en_r  <= '0;
            stop_en_r <= '0;
            dbl_r     <= '0;
            presc_r   <= '0;
        end else if (ce && cfg_load) begin
            for (int k = 0; k < NM; k++) match_reg_r[k] <= match_val[k];
            irq_en_r  <= irq_en;
            rst_en_r  <= rst_en;
            stop_en_r <= stop_en;
            dbl_r     <= dbl_edge;
            presc_r   <= prescale_max;
        end
    end

    // Compare every match register on the tick that would step the count.
    logic [NM-1:0] hit;
    logic [NM-1:0] rst_eff;
    always_comb begin
        hit = '0;
        for (int k = 0; k < NM; k++) begin
            hit[k] = tif.tick && (tif.tc == match_reg_r[k]);
        end
        rst_eff     = rst_en_r;
        rst_eff[C0] = 1'b1;
    end

    // Match actions steer the core; the cycle register always restarts the count.
    assign tif.run          = run;
    assign tif.clr          = cnt_clr;
    assign tif.prescale_max = presc_r;
    assign tif.match_rst    = |(hit & rst_eff);
    assign tif.match_stop   = |(hit & stop_en_r);

    // Next level of one pin; a rising edge wins when both land on one tick.
    function automatic logic edge_next(input logic cur, input logic rise, input logic fall);
        if (rise) edge_next = 1'b1;
        else if (fall) edge_next = 1'b0;
        else edge_next = cur;
    endfunction

    // Pin levels; output n falls on match n, rising source depends on its mode.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwm_out <= {NO{`MBPWM_OUT_RST}};
        end else if (ce) begin
            for (int n = 1; n <= NO; n++) begin
                if (n > 1 && dbl_r[n]) begin
                    pwm_out[n] <= edge_next(pwm_out[n], hit[n-1], hit[n]);
                end else begin
                    pwm_out[n] <= edge_next(pwm_out[n], hit[C0], hit[n]);
                end
            end
        end
    end

    // Interrupt requests are one-cycle pulses per enabled match.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            match_irq <= '0;
        end else if (ce) begin
            match_irq <= hit & irq_en_r;
        end
    end

    // Registered copies of the count and halt state for the pins.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_val <= '0;
            halted    <= `MBPWM_FLAG_RST;
        end else if (ce) begin
            count_val <= tif.tc;
            halted    <= (tif.state == mbpwm_pkg::RUN_HALT);
        end
    end

    // Mask of pins in single-edge mode, used by the checks below.
    logic [NO:1] single_m;
    always_comb begin
        single_m    = ~dbl_r;
        single_m[1] = 1'b1;
    end

    sequence cycle_hit_s;
        ce && hit[C0] && !tif.clr;
    endsequence

    cyc_restart_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        cycle_hit_s |=> (tif.tc == '0)
    ) else $error("cycle match did not restart the count");

    rise_at_start_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        cycle_hit_s |=> ((pwm_out & $past(single_m)) == $past(single_m))
    ) else $error("single-edge pin not high after cycle match");

    fall_on_edge_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && hit[1] && !hit[C0]) |=> !pwm_out[1]
    ) else $error("pin one did not fall on its edge match");

    hold_low_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && !pwm_out[1] && !hit[C0]) |=> !pwm_out[1]
    ) else $error("pin one rose without a cycle match");

    own_edge_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && single_m[3] && hit[2] && !hit[3] && !hit[C0]) |=> (pwm_out[3] == $past(pwm_out[3]))
    ) else $error("pin three moved on another pin's edge match");

    dbl_rise_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && dbl_r[2] && hit[1] && !hit[C0]) ##1 (ce && !hit[2] && !hit[1]) |=> pwm_out[2]
    ) else $error("double-edge pin did not rise and hold on its rise match");

    irq_pulse_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && |(hit & irq_en_r)) |=> |match_irq
            ##1 (!$past(ce) || match_irq == '0 || $past(|hit))
    ) else $error("match interrupt pulse missing or stuck");

    stop_pin_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && |(hit & stop_en_r & ~rst_eff) && run && !cnt_clr) ##1 ce |=> halted
    ) else $error("stop match did not show as halted");

endmodule

// *** common/mbpwm_regs.svh ***
// Named constants for the match based PWM unit.
`ifndef MBPWM_REGS_SVH
`define MBPWM_REGS_SVH

// Number of match registers and of pinned PWM outputs.
`define MBPWM_NUM_MATCH 7
`define MBPWM_NUM_OUT   6

// Default and smallest counter and prescaler width.
`define MBPWM_CNT_W     32
`define MBPWM_CNT_W_MIN 2

// Channel index of the cycle match register.
`define MBPWM_CYCLE_CH  0

// Reset values.
`define MBPWM_OUT_RST   1'b0
`define MBPWM_FLAG_RST  1'b0

`endif

// *** common/mbpwm_pkg.sv ***
// Types shared by the match based PWM unit.
package mbpwm_pkg;

    // Run state of the timer core.
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_COUNT,
        RUN_HALT
    } mbpwm_run_e;

endpackage

// *** common/mbpwm_tmr_if.sv ***
// Link between the match logic and the timer core.
`timescale 1ns/100ps
`include "mbpwm_regs.svh"

interface mbpwm_tmr_if #(
    parameter int CNT_W = `MBPWM_CNT_W
);
    logic                run;
    logic                clr;
    logic [CNT_W-1:0]    prescale_max;
    logic                match_rst;
    logic                match_stop;
    logic                tick;
    logic [CNT_W-1:0]    tc;
    mbpwm_pkg::mbpwm_run_e state;

    // The core owns the count, the matcher steers it.
    modport core (
        input  run,
        input  clr,
        input  prescale_max,
        input  match_rst,
        input  match_stop,
        output tick,
        output tc,
        output state
    );
    modport user (
        output run,
        output clr,
        output prescale_max,
        output match_rst,
        output match_stop,
        input  tick,
        input  tc,
        input  state
    );
endinterface

// *** src/mbpwm_core.sv ***
// Prescaler and timer counter of the match based PWM unit.
`timescale 1ns/100ps
`include "mbpwm_regs.svh"

module mbpwm_core #(
    parameter int CNT_W = `MBPWM_CNT_W
) (
    // Clock, enable and synchronised reset.
    input  wire logic  clk,
    input  wire logic  ce,
    input  wire logic  rst_sync_n,
    // Link to the match logic.
    mbpwm_tmr_if.core  tif
);

    logic [CNT_W-1:0] pc_r;
    logic [CNT_W-1:0] tc_r;
    mbpwm_pkg::mbpwm_run_e state_r;

    function automatic logic [CNT_W-1:0] incr(input logic [CNT_W-1:0] v);
        incr = CNT_W'(v + 1'b1);
    endfunction

    // One count step per prescaler wrap; the peripheral clock is the only source.
    assign tif.tick  = (state_r == mbpwm_pkg::RUN_COUNT) && (pc_r == tif.prescale_max);
    assign tif.tc    = tc_r;
    assign tif.state = state_r;

    // Run state; a stop match halts until software drops run or clears the count.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r <= mbpwm_pkg::RUN_IDLE;
        end else if (ce) begin
            if (tif.clr) begin
                state_r <= tif.run ? mbpwm_pkg::RUN_COUNT : mbpwm_pkg::RUN_IDLE;
            end else begin
                case (state_r)
                    mbpwm_pkg::RUN_IDLE: begin
                        if (tif.run) state_r <= mbpwm_pkg::RUN_COUNT;
                    end
                    mbpwm_pkg::RUN_COUNT: begin
                        if (!tif.run) state_r <= mbpwm_pkg::RUN_IDLE;
                        else if (tif.tick && tif.match_stop) state_r <= mbpwm_pkg::RUN_HALT;
                    end
                    mbpwm_pkg::RUN_HALT: begin
                        if (!tif.run) state_r <= mbpwm_pkg::RUN_IDLE;
                    end
                    default: state_r <= mbpwm_pkg::RUN_IDLE;
                endcase
            end
        end
    end

    // Prescaler divides the clock before the timer counter sees it.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pc_r <= '0;
        end else if (ce) begin
            if (tif.clr || tif.tick) pc_r <= '0;
            else if (state_r == mbpwm_pkg::RUN_COUNT) pc_r <= incr(pc_r);
        end
    end

    // Timer counter; a reset match wins over a stop match, which holds the value.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tc_r <= '0;
        end else if (ce) begin
            if (tif.clr) tc_r <= '0;
            else if (tif.tick) begin
                if (tif.match_rst) tc_r <= '0;
                else if (!tif.match_stop) tc_r <= incr(tc_r);
            end
        end
    end

    // Helper for the prescaler check: counting cycles since the last tick.
    logic [CNT_W-1:0] gap_r;
    logic             seen_r;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gap_r  <= '0;
            seen_r <= `MBPWM_FLAG_RST;
        end else if (ce) begin
            if (tif.clr) begin
                gap_r  <= '0;
                seen_r <= `MBPWM_FLAG_RST;
            end else if (tif.tick) begin
                gap_r  <= '0;
                seen_r <= 1'b1;
            end else if (state_r == mbpwm_pkg::RUN_COUNT) gap_r <= incr(gap_r);
        end
    end

    prescale_gap_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && tif.tick && seen_r) |-> (gap_r == tif.prescale_max)
    ) else $error("prescaler gap differs from programmed divide");

    count_step_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (ce && tif.tick && !tif.clr && !tif.match_rst && !tif.match_stop)
            |=> (tc_r == CNT_W'($past(tc_r) + 1'b1))
    ) else $error("counter did not advance by one on a tick");

    sequence stop_hit_s;
        ce && tif.tick && tif.match_stop && tif.run && !tif.clr;
    endsequence

    stop_freeze_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        stop_hit_s ##1 (ce && tif.run && !tif.clr)
            |=> (state_r == mbpwm_pkg::RUN_HALT) && $stable(tc_r)
    ) else $error("counter kept running after a stop match");

endmodule

// *** verif/mbpwm_load.sv ***
// Behavioural model of the external power stages driven by the PWM pins.
`timescale 1ns/100ps

module mbpwm_load (
    // Clock and measurement clear.
    input  wire logic             clk,
    input  wire logic             clr,
    // Gate drives from the PWM pins.
    input  wire logic [6:1]       drive,
    // On-time of each switch, in clock cycles.
    output logic      [15:0]      on_cnt [1:6]
);
    // A switch conducts only on a clean high drive, so an unknown pin level
    // never adds on-time and shows up as a shortfall in the count.
    always_ff @(posedge clk) begin
        for (int i = 1; i <= 6; i++) begin
            if (clr) begin
                on_cnt[i] <= 16'h0000;
            end else if (drive[i] === 1'b1) begin
                on_cnt[i] <= on_cnt[i] + 16'h0001;
            end
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking testbench for the match based PWM unit.
`timescale 1ns/100ps
`include "mbpwm_regs.svh"

module testbench;
    logic                              clk;
    logic                              ce;
    logic                              rst_n;
    logic                              run;
    logic                              cnt_clr;
    logic                              cfg_load;
    logic [31:0]                       prescale_max;
    logic [`MBPWM_NUM_MATCH-1:0][31:0] match_val;
    logic [`MBPWM_NUM_MATCH-1:0]       irq_en;
    logic [`MBPWM_NUM_MATCH-1:0]       rst_en;
    logic [`MBPWM_NUM_MATCH-1:0]       stop_en;
    logic [`MBPWM_NUM_OUT:1]           dbl_edge;
    logic [`MBPWM_NUM_OUT:1]           pwm_out;
    logic [`MBPWM_NUM_MATCH-1:0]       match_irq;
    logic [31:0]                       count_val;
    logic                              halted;
    logic                              ld_clr;
    logic [15:0]                       on_cnt [1:6];
    logic [31:0]                       irq1_n;
    logic [31:0]                       irqx_n;
    logic [31:0]                       max_cnt;
    logic [31:0]                       all_hi_n;
    int                                err_count;
    int                                n_checks;

    mbpwm_unit mbpwm_unit_inst (
        .clk(clk), .ce(ce), .rst_n(rst_n), .run(run), .cnt_clr(cnt_clr),
        .cfg_load(cfg_load), .prescale_max(prescale_max), .match_val(match_val),
        .irq_en(irq_en), .rst_en(rst_en), .stop_en(stop_en), .dbl_edge(dbl_edge),
        .pwm_out(pwm_out), .match_irq(match_irq), .count_val(count_val),
        .halted(halted)
    );

    mbpwm_load mbpwm_load_inst (
        .clk(clk), .clr(ld_clr), .drive(pwm_out), .on_cnt(on_cnt)
    );

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Loads a full setting and restarts the count; the clear rides on the
    // same edge so every scenario starts from a count of zero.
    task automatic cfg(input logic [31:0] p, input logic [6:0][31:0] m, input logic [6:0] ie,
                       input logic [6:0] re, input logic [6:0] se, input logic [6:1] de);
        @(posedge clk);
        prescale_max <= p;
        match_val <= m;
        irq_en <= ie;
        rst_en <= re;
        stop_en <= se;
        dbl_edge <= de;
        cfg_load <= 1'b1;
        cnt_clr <= 1'b1;
        run <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        cnt_clr <= 1'b0;
        repeat (40) @(posedge clk);
    endtask

    // Watches n cycles; windows are whole periods so the phase does not matter.
    task automatic measure(input int n);
        irq1_n = 32'h0;
        irqx_n = 32'h0;
        max_cnt = 32'h0;
        all_hi_n = 32'h0;
        @(posedge clk);
        ld_clr <= 1'b1;
        @(posedge clk);
        ld_clr <= 1'b0;
        repeat (n) begin
            @(negedge clk);
            irq1_n += {31'h0, match_irq[1]};
            irqx_n += 32'($countones(match_irq & 7'h7D));
            if (count_val > max_cnt) max_cnt = count_val;
            if (pwm_out === 6'h3F) all_hi_n += 32'h1;
        end
        @(negedge clk);
    endtask

    // Single-edge duties on all pins, one pin never reaching its edge; then a
    // low clock enable must freeze count and pins, and counting resumes after.
    task automatic t_duty();
        logic [31:0] held;
        logic [6:1]  pins;
        cfg(32'h0, {32'hC, 32'h5, 32'h4, 32'h3, 32'h2, 32'h1, 32'h9}, 7'h02, 7'h00, 7'h00, 6'h00);
        measure(20);
        for (int i = 1; i <= 5; i++) begin
            chk("on_cnt", 32'(2 * (i + 1)), {16'h0, on_cnt[i]});
        end
        chk("on_cnt6", 32'd20, {16'h0, on_cnt[6]});
        chk("all_high", 32'd4, all_hi_n);
        chk("irq1", 32'd2, irq1_n);
        chk("irq_other", 32'd0, irqx_n);
        chk("max_count", 32'h9, max_cnt);
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(negedge clk);
        held = count_val;
        pins = pwm_out;
        repeat (6) @(negedge clk);
        chk("ce_count", held, count_val);
        chk("ce_pins", {26'h0, pins}, {26'h0, pwm_out});
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(negedge clk);
        chk("ce_resume", (held + 32'h2) % 32'hA, count_val);
    endtask

    // Prescaler stretches every tick to three clocks.
    task automatic t_presc();
        cfg(32'h2, {32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h1, 32'h4}, 7'h00, 7'h00, 7'h00, 6'h00);
        measure(30);
        chk("presc_on1", 32'd12, {16'h0, on_cnt[1]});
        chk("presc_max", 32'h4, max_cnt);
    endtask

    // Pin 2 rises on match 1 and falls on match 2.
    task automatic t_dual();
        cfg(32'h0, {32'h9, 32'h9, 32'h9, 32'h9, 32'h6, 32'h2, 32'h9}, 7'h00, 7'h00, 7'h00, 6'h02);
        measure(20);
        chk("dual_on2", 32'd8, {16'h0, on_cnt[2]});
        chk("dual_on1", 32'd6, {16'h0, on_cnt[1]});
    endtask

    // A reset on match 2 shortens the period, then run low freezes the count.
    // The cycle register is never reached, so pin 1 never rises again.
    task automatic t_rstmatch();
        logic [31:0] held;
        cfg(32'h0, {32'h9, 32'h9, 32'h9, 32'h9, 32'h3, 32'h1, 32'h9}, 7'h00, 7'h04, 7'h00, 6'h00);
        measure(20);
        chk("rst_on1", 32'd0, {16'h0, on_cnt[1]});
        chk("rst_max", 32'h3, max_cnt);
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(negedge clk);
        held = count_val;
        repeat (6) @(negedge clk);
        chk("paused", held, count_val);
    endtask

    // Stop on match 3 holds the count at its match value until cleared.
    task automatic t_stop();
        int i;
        cfg(32'h0, {32'h9, 32'h9, 32'h9, 32'h5, 32'h9, 32'h9, 32'h9}, 7'h00, 7'h00, 7'h08, 6'h00);
        chk("halted", 32'h1, {31'h0, halted});
        chk("stop_count", 32'h5, count_val);
        @(posedge clk);
        cnt_clr <= 1'b1;
        @(posedge clk);
        cnt_clr <= 1'b0;
        repeat (2) @(negedge clk);
        chk("resumed", 32'h0, {31'h0, halted});
        i = 0;
        while (halted !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        if (i == 20) begin
            err_count++;
            end_sim();
        end
        chk("stop_again", 32'h5, count_val);
    endtask

    // Main sequence; all inputs hold a value from time zero.
    initial begin
        ce = 1'b1;
        rst_n = 1'b0;
        run = 1'b0;
        cnt_clr = 1'b0;
        cfg_load = 1'b0;
        prescale_max = 32'h0;
        match_val = '0;
        irq_en = 7'h00;
        rst_en = 7'h00;
        stop_en = 7'h00;
        dbl_edge = 6'h00;
        ld_clr = 1'b0;
        err_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reset_pins", 32'h0, {26'h0, pwm_out});
        t_duty();
        t_presc();
        t_dual();
        t_rstmatch();
        t_stop();
        end_sim();
    end
endmodule
